// ---- hdl/valve_position_supervisor.sv ----
// Valve position supervisor: band checks, service counters, device reset
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module valve_position_supervisor #(
  parameter int unsigned HOLD_CYC = valve_sup_pkg::HOLD_CYC,
  parameter int unsigned ARM_CYC  = valve_sup_pkg::ARM_CYC,
  parameter int unsigned SEC_CYC  = valve_sup_pkg::SEC_CYC,
  parameter int unsigned DAY_SEC  = valve_sup_pkg::DAY_SEC
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst_b,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [15:0]                 i_pos_ext,
  input  wire logic [15:0]                 i_pos_int,
  input  wire logic [2:0]                  i_valve_switch,
  input  wire logic                        teach_button_one,
  input  wire logic                        teach_button_two,
  input  wire logic                        teach_button_three,
  output valve_sup_pkg::valve_state_t      o_valve_state,
  output logic                             o_maint_request,
  output logic                             o_maint_blink,
  output logic                             o_manual_enable,
  output logic                             o_reset_armed,
  output logic                             o_reset_done
);
  import valve_sup_pkg::*;

  if (ARM_CYC < 2 || SEC_CYC < 2 || DAY_SEC < 1) begin : g_chk
    $error("valve_position_supervisor: timing parameters too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // True when pos sits within [tgt - minus, tgt + plus]
  function automatic logic in_band(input logic [15:0] pos,
                                   input logic [15:0] tgt,
                                   input tol_t        tol);
    logic [16:0] hi;
    logic [16:0] lo;
    hi = {1'b0, tgt} + {1'b0, tol.plus};
    lo = {1'b0, tgt} - {1'b0, tol.minus};
    // Negative low edge wraps above 16 bits: treat as zero
    if (lo[16]) lo = 17'h0;
    in_band = ({1'b0, pos} >= lo) && ({1'b0, pos} <= hi);
  endfunction : in_band

  // Band side is acceptable only between 0.50 and 10.00 mm
  function automatic logic tol_ok(input logic [15:0] v);
    tol_ok = (v >= TOL_MIN) && (v <= TOL_MAX);
  endfunction : tol_ok

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] tgt_r      [4];
  logic [3:0]  taught_r;
  tol_t        tol_r      [4];
  logic [7:0]  ivl_r      [3];
  logic [15:0] day_ivl_r;
  logic [31:0] cnt_r      [3];
  logic [31:0] life_r     [3];
  logic [31:0] days_r;
  logic [31:0] days_life_r;
  logic        notif_en_r;
  logic        manual_en_r;
  logic [31:0] sec_div_r;
  logic [31:0] sec_cnt_r;
  logic        blink_r;
  logic [31:0] arm_cnt_r;
  arm_state_t  arm_state_r;
  arm_state_t  arm_state_nxt;
  logic        maint_r;
  valve_state_t state_r;
  logic [31:0] prdata_r;
  logic        done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: no wait states, unmapped access gives an error
  wire        wr_en    = psel && penable && pwrite;
  wire        setup    = psel && !penable;
  wire [5:0]  widx     = paddr[7:2];
  wire        wr_ctrl  = wr_en && (paddr == OFF_CTRL);
  wire        wr_dayi  = wr_en && (paddr == OFF_DAY_IVL);
  wire        frst_cmd = wr_ctrl && pwdata[CTRL_FRST_BIT];
  logic       mapped;
  logic [31:0] rd_mux;

  // Read mux and map check share one decode chain
  always_comb begin
    rd_mux = 32'h0;
    mapped = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (paddr == OFF_CTRL) begin
      rd_mux = {29'h0, 1'b0, manual_en_r, notif_en_r};
    end else if (paddr == OFF_STATUS) begin
      rd_mux = {22'h0, arm_state_r == ARM_WAIT, maint_r, taught_r,
                state_r};
    end else if (paddr >= OFF_TGT && paddr < OFF_TOL) begin
      rd_mux = {16'h0, tgt_r[widx[1:0]]};
    end else if (paddr >= OFF_TOL && paddr < OFF_IVL) begin
      rd_mux = tol_r[widx[1:0]];
    end else if (paddr >= OFF_IVL && paddr < OFF_DAY_IVL) begin
      rd_mux = {24'h0, ivl_r[2'(widx - (OFF_IVL >> 2))]};
    end else if (paddr == OFF_DAY_IVL) begin
      rd_mux = {16'h0, day_ivl_r};
    end else if (paddr >= OFF_CNT && paddr < OFF_LIFE) begin
      rd_mux = cnt_r[2'(widx - (OFF_CNT >> 2))];
    end else if (paddr >= OFF_LIFE && paddr < OFF_DAYS) begin
      rd_mux = life_r[2'(widx - (OFF_LIFE >> 2))];
    end else if (paddr == OFF_DAYS) begin
      rd_mux = days_r;
    end else if (paddr == OFF_DAYS_LIFE) begin
      rd_mux = days_life_r;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_r;

  // Read data is caught in the setup cycle so it leaves a flip-flop
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) prdata_r <= 32'h0;
    else if (setup && !pwrite) prdata_r <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three-button combination and the reset-armed window
  logic combo_fire;

  combo_hold #(
    .HOLD_CYC (HOLD_CYC)
  ) u_combo (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_buttons ({teach_button_three, teach_button_two, teach_button_one}),
    .o_fire    (combo_fire)
  );

  wire arm_timeout = (arm_state_r == ARM_WAIT) && (arm_cnt_r == ARM_CYC - 1);
  wire btn_reset   = (arm_state_r == ARM_WAIT) && combo_fire;
  wire dev_reset   = btn_reset || frst_cmd;

  // Armed-mode transitions
  always_comb begin
    arm_state_nxt = arm_state_r;
    case (arm_state_r)
      ARM_IDLE: if (combo_fire) arm_state_nxt = ARM_WAIT;
      ARM_WAIT: if (btn_reset || arm_timeout) arm_state_nxt = ARM_IDLE;
      default:  arm_state_nxt = ARM_IDLE;
    endcase
  end

  // Window count restarts each time the mode is entered
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arm_state_r <= ARM_IDLE;
      arm_cnt_r   <= 32'h0;
    end else begin
      arm_state_r <= arm_state_nxt;
      if (arm_state_r == ARM_WAIT) arm_cnt_r <= arm_cnt_r + 32'h1;
      else arm_cnt_r <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Taught positions and tolerance bands; a reset wins over a write
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      taught_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        tgt_r[i]       <= 16'h0;
        tol_r[i].plus  <= TOL_DEF;
        tol_r[i].minus <= (i == 3) ? TOL_DEF_LOW4 : TOL_DEF;
      end
    end else if (dev_reset) begin
      taught_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        tol_r[i].plus  <= TOL_DEF;
        tol_r[i].minus <= (i == 3) ? TOL_DEF_LOW4 : TOL_DEF;
      end
    end else if (wr_en && paddr >= OFF_TGT && paddr < OFF_TOL) begin
      tgt_r[widx[1:0]]    <= pwdata[15:0];
      taught_r[widx[1:0]] <= 1'b1;
    end else if (wr_en && paddr >= OFF_TOL && paddr < OFF_IVL) begin
      // A side outside 0.50..10.00 mm keeps its old value
      if (tol_ok(pwdata[15:0])) tol_r[widx[1:0]].plus <= pwdata[15:0];
      if (tol_ok(pwdata[31:16])) begin
        tol_r[widx[1:0]].minus <= pwdata[31:16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration flags and service intervals
  wire ivl_wr = wr_en && paddr >= OFF_IVL && paddr < OFF_DAY_IVL;
  wire [1:0] ivl_i = 2'(widx - (OFF_IVL >> 2));

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      notif_en_r  <= 1'b0;
      manual_en_r <= 1'b1;
      day_ivl_r   <= DAY_IVL_DEF;
      ivl_r[0]    <= IVL_DEF_ONE;
      ivl_r[1]    <= IVL_DEF;
      ivl_r[2]    <= IVL_DEF;
    end else if (dev_reset) begin
      notif_en_r  <= 1'b0;
      manual_en_r <= 1'b1;
      day_ivl_r   <= DAY_IVL_DEF;
      ivl_r[0]    <= IVL_DEF_ONE;
      ivl_r[1]    <= IVL_DEF;
      ivl_r[2]    <= IVL_DEF;
    end else begin
      if (wr_ctrl) begin
        notif_en_r  <= pwdata[CTRL_NOTIF_BIT];
        manual_en_r <= pwdata[CTRL_MANUAL_BIT];
      end
      // Zero steps or zero days is out of range and ignored
      if (ivl_wr && pwdata[7:0] != 8'h0) begin
        ivl_r[ivl_i] <= pwdata[7:0];
      end
      if (wr_dayi && pwdata[15:0] != 16'h0) begin
        day_ivl_r <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching-cycle counters; lifetime ones ignore the device reset
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 3; i++) begin
        cnt_r[i]  <= 32'h0;
        life_r[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (dev_reset) cnt_r[i] <= 32'h0;
        else if (i_valve_switch[i] && cnt_r[i] != 32'hffff_ffff) begin
          cnt_r[i] <= cnt_r[i] + 32'h1;
        end
        if (i_valve_switch[i] && life_r[i] != 32'hffff_ffff) begin
          life_r[i] <= life_r[i] + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second and day time base; the second tick also paces the blink
  wire sec_tick = (sec_div_r == SEC_CYC - 1);
  wire day_tick = sec_tick && (sec_cnt_r == DAY_SEC - 1);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sec_div_r <= 32'h0;
      sec_cnt_r <= 32'h0;
      blink_r   <= 1'b0;
    end else begin
      sec_div_r <= sec_tick ? 32'h0 : sec_div_r + 32'h1;
      if (sec_tick) begin
        sec_cnt_r <= day_tick ? 32'h0 : sec_cnt_r + 32'h1;
        blink_r   <= !blink_r;
      end
    end
  end

  // Operating duration in days, resettable and lifetime
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      days_r      <= 32'h0;
      days_life_r <= 32'h0;
    end else begin
      if (dev_reset) days_r <= 32'h0;
      else if (day_tick) days_r <= days_r + 32'h1;
      if (day_tick) days_life_r <= days_life_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Maintenance request: any cycle counter or the duration at its interval
  logic [2:0] cyc_due;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cyc_due[i] = cnt_r[i] >= 32'(ivl_r[i] * IVL_STEP);
    end
  end

  wire day_due = days_r >= {16'h0, day_ivl_r};

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) maint_r <= 1'b0;
    else maint_r <= notif_en_r && !dev_reset && ((|cyc_due) || day_due);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position feedback: external sensor for points one and two, internal
  // sensor for three and four; readings beyond the stroke never match
  wire ext_ok = i_pos_ext <= EXT_MAX;
  wire int_ok = i_pos_int <= INT_MAX;
  valve_state_t state_nxt;

  assign state_nxt.closed     = taught_r[0] && ext_ok
                              && in_band(i_pos_ext, tgt_r[0], tol_r[0]);
  assign state_nxt.open       = taught_r[1] && ext_ok
                              && in_band(i_pos_ext, tgt_r[1], tol_r[1]);
  assign state_nxt.upper_lift = taught_r[2] && int_ok
                              && in_band(i_pos_int, tgt_r[2], tol_r[2]);
  assign state_nxt.lower_lift = taught_r[3] && int_ok
                              && in_band(i_pos_int, tgt_r[3], tol_r[3]);

  // Registered so the report only holds while the sample stays in band
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) state_r <= '0;
    else state_r <= state_nxt;
  end

  // Reset indication: one-cycle pulse after the reset is carried out
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) done_r <= 1'b0;
    else done_r <= dev_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_valve_state   = state_r;
  assign o_maint_request = maint_r;
  assign o_maint_blink   = maint_r && blink_r;
  assign o_manual_enable = manual_en_r;
  assign o_reset_armed   = (arm_state_r == ARM_WAIT);
  assign o_reset_done    = done_r;

endmodule : valve_position_supervisor

// ---- hdl/valve_sup_pkg.sv ----
// Shared constants and types for the valve position supervisor
package valve_sup_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing; positions and bands are in 0.01 mm units
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned HOLD_MS    = 2_500;
  localparam int unsigned ARM_MS     = 10_000;
  localparam int unsigned HOLD_CYC   = HOLD_MS * (CLK_HZ / 1_000);
  localparam int unsigned ARM_CYC    = ARM_MS * (CLK_HZ / 1_000);
  localparam int unsigned SEC_CYC    = CLK_HZ;
  localparam int unsigned DAY_SEC    = 86_400;

  ////////////////////////////////////////////////////////////////////////////
  // Stroke limits, bands, intervals
  localparam logic [15:0] EXT_MAX      = 16'h0fa0;  // 40.00 mm
  localparam logic [15:0] INT_MAX      = 16'h1f40;  // 80.00 mm
  localparam logic [15:0] TOL_DEF      = 16'h0064;  // 1.00 mm
  localparam logic [15:0] TOL_DEF_LOW4 = 16'h012c;  // 3.00 mm
  localparam logic [15:0] TOL_MIN      = 16'h0032;  // 0.50 mm
  localparam logic [15:0] TOL_MAX      = 16'h03e8;  // 10.00 mm
  localparam logic [7:0]  IVL_DEF_ONE  = 8'h0a;     // 10 x 1000 cycles
  localparam logic [7:0]  IVL_DEF      = 8'h32;     // 50 x 1000 cycles
  localparam logic [31:0] IVL_STEP     = 32'h0000_03e8;
  localparam logic [15:0] DAY_IVL_DEF  = 16'h016d;  // 365 days

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses); arrays step by four bytes
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_TGT       = 8'h10;
  localparam logic [7:0] OFF_TOL       = 8'h20;
  localparam logic [7:0] OFF_IVL       = 8'h30;
  localparam logic [7:0] OFF_DAY_IVL   = 8'h3c;
  localparam logic [7:0] OFF_CNT       = 8'h40;
  localparam logic [7:0] OFF_LIFE      = 8'h4c;
  localparam logic [7:0] OFF_DAYS      = 8'h58;
  localparam logic [7:0] OFF_DAYS_LIFE = 8'h5c;

  // Field positions
  localparam int CTRL_NOTIF_BIT  = 0;
  localparam int CTRL_MANUAL_BIT = 1;
  localparam int CTRL_FRST_BIT   = 2;
  localparam int ST_REACHED_LSB  = 0;
  localparam int ST_TAUGHT_LSB   = 4;
  localparam int ST_MAINT_BIT    = 8;
  localparam int ST_ARMED_BIT    = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic lower_lift;
    logic upper_lift;
    logic open;
    logic closed;
  } valve_state_t;

  typedef struct packed {
    logic [15:0] minus;
    logic [15:0] plus;
  } tol_t;

  typedef enum {ARM_IDLE, ARM_WAIT} arm_state_t;

endpackage : valve_sup_pkg

// ---- hdl/combo_hold.sv ----
// Three-button hold detector: one pulse per continuous hold
`timescale 1ns/1ps
module combo_hold #(
  parameter int unsigned HOLD_CYC = valve_sup_pkg::HOLD_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_buttons,
  output logic            o_fire
);
  import valve_sup_pkg::*;

  if (HOLD_CYC < 2) begin : g_chk
    $error("combo_hold: HOLD_CYC must be at least 2");
  end

  logic [31:0] cnt_r;
  logic        done_r;
  wire         all_held = &i_buttons;
  wire         reach    = all_held && !done_r && (cnt_r == HOLD_CYC - 1);

  // Any release clears the count, so a short press changes nothing
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r  <= 32'h0;
      done_r <= 1'b0;
    end else if (!all_held) begin
      cnt_r  <= 32'h0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      cnt_r  <= cnt_r + 32'h1;
      done_r <= reach;  // Fire once, then wait for release
    end
  end

  assign o_fire = reach;

endmodule : combo_hold

// ---- dv/valve_sup_assertions.sv ----
// Port-level assertions for the valve position supervisor
`timescale 1ns/1ps
module valve_sup_assertions #(
  parameter int unsigned HOLD_CYC = valve_sup_pkg::HOLD_CYC,
  parameter int unsigned ARM_CYC  = valve_sup_pkg::ARM_CYC
) (
  input wire logic                        i_ref_clk,
  input wire logic                        i_rst_b,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [15:0]                 i_pos_ext,
  input wire logic [15:0]                 i_pos_int,
  input wire logic                        teach_button_one,
  input wire logic                        teach_button_two,
  input wire logic                        teach_button_three,
  input wire valve_sup_pkg::valve_state_t o_valve_state,
  input wire logic                        o_maint_request,
  input wire logic                        o_maint_blink,
  input wire logic                        o_manual_enable,
  input wire logic                        o_reset_armed,
  input wire logic                        o_reset_done
);
  import valve_sup_pkg::*;
  logic [31:0] hold_cnt;
  logic [31:0] arm_cnt;
  wire         all_held;
  assign all_held = teach_button_one & teach_button_two & teach_button_three;

  ////////////////////////////////////////////////////////////////////////////
  // Run lengths; the hold count saturates so it cannot wrap on long holds
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_cnt <= '0;
      arm_cnt  <= '0;
    end else begin
      hold_cnt <= !all_held ? '0 :
                  (hold_cnt < HOLD_CYC) ? hold_cnt + 1 : hold_cnt;
      arm_cnt  <= o_reset_armed ? arm_cnt + 1 : '0;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Service bus, stroke limits, notification and reset sequence
  a_pready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_ext_stroke: assert property ((i_pos_ext > EXT_MAX) |=>
    !o_valve_state.closed && !o_valve_state.open)
    else $error("external point reached beyond stroke");
  a_int_stroke: assert property ((i_pos_int > INT_MAX) |=>
    !o_valve_state.upper_lift && !o_valve_state.lower_lift)
    else $error("internal point reached beyond stroke");
  a_blink_gated: assert property (o_maint_blink |-> o_maint_request)
    else $error("blink without maintenance request");
  a_arm_hold: assert property ($rose(o_reset_armed) |->
    hold_cnt >= HOLD_CYC)
    else $error("armed without a full hold");
  a_arm_timeout: assert property (arm_cnt <= ARM_CYC + 1)
    else $error("armed mode outlived its limit");
  a_done_pulse: assert property (o_reset_done |=> !o_reset_done)
    else $error("reset done longer than one cycle");
  a_done_state: assert property (o_reset_done |->
    !o_reset_armed && o_manual_enable)
    else $error("reset left armed or manual off");
  a_done_maint: assert property (o_reset_done |=> !o_maint_request)
    else $error("maintenance request survived reset");
endmodule : valve_sup_assertions

bind valve_position_supervisor valve_sup_assertions #(
  .HOLD_CYC(HOLD_CYC),
  .ARM_CYC(ARM_CYC)
) u_assert (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .i_pos_ext(i_pos_ext), .i_pos_int(i_pos_int),
  .teach_button_one(teach_button_one),
  .teach_button_two(teach_button_two),
  .teach_button_three(teach_button_three),
  .o_valve_state(o_valve_state), .o_maint_request(o_maint_request),
  .o_maint_blink(o_maint_blink), .o_manual_enable(o_manual_enable),
  .o_reset_armed(o_reset_armed), .o_reset_done(o_reset_done)
);

// ---- dv/button_operator.sv ----
// Operator model that holds the three teach buttons for a set time
`timescale 1ns/1ps
module button_operator (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  output logic      [2:0] o_buttons,
  output logic            o_busy
);
  logic [7:0] left_r;

  // Buttons move together; a hold shorter than the limit is an early release
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      left_r <= 8'h00;
    end else if (i_go) begin
      left_r <= i_len;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end
  assign o_busy    = (left_r != 8'h00);
  assign o_buttons = {3{o_busy}};
endmodule : button_operator

// ---- dv/tb_top.sv ----
// Self-checking bench for the valve position supervisor
`timescale 1ns/1ps
module tb_top;
  import valve_sup_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int unsigned ARM  = 100;
  typedef struct packed {
    logic [15:0] ext;
    logic [15:0] pint;
    logic [3:0]  exp;
  } row_t;
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, go = 1'b0, busy, er;
  logic [7:0] paddr = 8'h00, len = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] i_pos_ext = 16'h03e8, i_pos_int = 16'h0000;
  logic [2:0] i_valve_switch = 3'h0, btn;
  valve_state_t o_valve_state;
  logic o_maint_request, o_maint_blink, o_manual_enable;
  logic o_reset_armed, o_reset_done;
  int checks = 0, miscompares = 0, cyc = 0, dones = 0, n;
  row_t rows [6] = '{'{16'h03e8, 16'h0000, 4'h1},
    '{16'h044c, 16'h07d0, 4'h5}, '{16'h0383, 16'h1644, 4'h8},
    '{16'h0c1d, 16'h1643, 4'h0}, '{16'h0b54, 16'h0835, 4'h2},
    '{16'hffff, 16'hffff, 4'h0}};

  valve_position_supervisor #(.HOLD_CYC(HOLD), .ARM_CYC(ARM),
    .SEC_CYC(4), .DAY_SEC(30)) DUT (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_pos_ext(i_pos_ext), .i_pos_int(i_pos_int),
    .i_valve_switch(i_valve_switch), .teach_button_one(btn[0]),
    .teach_button_two(btn[1]), .teach_button_three(btn[2]),
    .o_valve_state(o_valve_state), .o_maint_request(o_maint_request),
    .o_maint_blink(o_maint_blink), .o_manual_enable(o_manual_enable),
    .o_reset_armed(o_reset_armed), .o_reset_done(o_reset_done));
  button_operator u_op (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_go(go), .i_len(len), .o_buttons(btn), .o_busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and reset-done pulse counter
  always #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc++;
    if (o_reset_done === 1'b1) dones++;
    if (cyc == 15000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, got);
    checks++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, got);
    end
  endtask : chk

  // Setup then access; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a stuck wait
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk

  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask : tick

  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge i_ref_clk);
      i_valve_switch <= 3'h7;
      @(posedge i_ref_clk);
      i_valve_switch <= 3'h0;
    end
  endtask : pulse

  task automatic press(input logic [7:0] l);
    @(posedge i_ref_clk);
    go <= 1'b1;
    len <= l;
    @(posedge i_ref_clk);
    go <= 1'b0;
    tick(l + 1);
  endtask : press

  task automatic pos(input logic [15:0] e, input logic [15:0] i);
    @(posedge i_ref_clk);
    i_pos_ext <= e;
    i_pos_int <= i;
    tick(2);
  endtask : pos

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    tick(1);
    chk("state", 32'h0, {28'h0, o_valve_state});
    rchk(OFF_CTRL, 32'h0000_0002);
    rchk(OFF_TOL, 32'h0064_0064);
    rchk(OFF_TOL + 8'h0c, 32'h012c_0064);
    rchk(OFF_IVL, 32'h0000_000a);
    rchk(OFF_IVL + 8'h08, 32'h0000_0032);
    rchk(OFF_DAY_IVL, 32'h0000_016d);
    apb(1'b0, 8'hfc, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    wr(OFF_TGT, 32'h03e8);
    wr(OFF_TGT + 8'h04, 32'h0bb8);
    wr(OFF_TGT + 8'h08, 32'h07d0);
    wr(OFF_TGT + 8'h0c, 32'h1770);
    foreach (rows[i]) begin
      pos(rows[i].ext, rows[i].pint);
      chk("state", {28'h0, rows[i].exp}, {28'h0, o_valve_state});
    end
    wr(OFF_TOL, 32'h0064_00c8);
    wr(OFF_TOL, 32'h0032_03e9);
    rchk(OFF_TOL, 32'h0032_00c8);
    pos(16'h04b0, 16'h0000);
    chk("widened", 32'h1, {28'h0, o_valve_state});
    pos(16'h03b5, 16'h0000);
    chk("narrowed", 32'h0, {28'h0, o_valve_state});
    wr(OFF_CTRL, 32'h0);
    tick(2);
    chk("manual", 32'h0, {31'h0, o_manual_enable});
    wr(OFF_IVL, 32'h1);
    pulse(1000);
    tick(3);
    chk("maint off", 32'h0, {31'h0, o_maint_request});
    wr(OFF_CTRL, 32'h1);
    tick(3);
    chk("maint", 32'h1, {31'h0, o_maint_request});
    n = 0;
    // Two full blink periods give half high whatever the phase
    repeat (16) begin
      tick(1);
      n += (o_maint_blink === 1'b1);
    end
    chk("blink", 32'd8, n);
    tick(4);
    wr(OFF_IVL, 32'h2);
    pulse(999);
    tick(3);
    chk("maint 1999", 32'h0, {31'h0, o_maint_request});
    pulse(1);
    tick(3);
    chk("maint 2000", 32'h1, {31'h0, o_maint_request});
    rchk(OFF_CNT + 8'h04, 32'h0000_07d0);
    wr(OFF_IVL, 32'hff);
    tick(3);
    chk("maint 255", 32'h0, {31'h0, o_maint_request});
    wr(OFF_DAY_IVL, 32'h1);
    wr(OFF_DAY_IVL, 32'h0);
    tick(3);
    chk("maint days", 32'h1, {31'h0, o_maint_request});
    rchk(OFF_DAY_IVL, 32'h0000_0001);
    press(HOLD / 2);
    chk("armed early", 32'h0, {31'h0, o_reset_armed});
    press(HOLD);
    chk("armed", 32'h1, {31'h0, o_reset_armed});
    tick(ARM + 5);
    chk("armed left", 32'h0, {31'h0, o_reset_armed});
    press(HOLD);
    press(HOLD);
    chk("done", 32'h1, dones);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h0, rd & 32'h0000_03f0);
    rchk(OFF_CTRL, 32'h0000_0002);
    rchk(OFF_TOL, 32'h0064_0064);
    rchk(OFF_IVL, 32'h0000_000a);
    rchk(OFF_DAY_IVL, 32'h0000_016d);
    rchk(OFF_CNT, 32'h0);
    rchk(OFF_DAYS, 32'h0);
    rchk(OFF_LIFE, 32'h0000_07d0);
    pos(16'h03e8, 16'h0000);
    chk("untaught", 32'h0, {28'h0, o_valve_state});
    wr(OFF_TOL, 32'h00c8_00c8);
    wr(OFF_TGT, 32'h03e8);
    wr(OFF_CTRL, 32'h5);
    rchk(OFF_TOL, 32'h0064_0064);
    rchk(OFF_CTRL, 32'h0000_0002);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("taught", 32'h0, rd & 32'h0000_00f0);
    finish_test();
  end
endmodule : tb_top
